/* File: include/ebp_pkg.sv */
// shared constants for the external bus pin-state controller
// How it works
// - power-on reset: strobes, area0/1 high, bus floats
// - sleep keeps port pin directions and drive
// - external access lowers only addressed area select
// - internal or unaddressed areas keep selects high
// - read strobe on reads, byte strobes on writes
// - data lanes follow access width, else float
package ebp_pkg;
  localparam int ADDR_W = 21;
  localparam int AREA_W = 2;
  localparam int NUM_AREAS = 4;
  localparam int PORT_W = 11;
  // access target codes
  localparam logic [1:0] TGT_INT_RAM = 2'h0;
  localparam logic [1:0] TGT_MODULE = 2'h1;
  localparam logic [1:0] TGT_EXTERNAL = 2'h2;
  // access size codes
  localparam logic [1:0] SZ_UPPER = 2'h0;
  localparam logic [1:0] SZ_LOWER = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;
  // idle values
  localparam logic STROBE_IDLE = 1'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
endpackage

/* File: rtl/ebp_pin_ctrl.sv */
// external bus pin-state controller: selects, strobes, address and data lanes
module ebp_pin_ctrl #(
  parameter int PORT_W = ebp_pkg::PORT_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic sleep_i,
  input wire logic acc_valid_i,
  input wire logic [1:0] acc_target_i,
  input wire logic [1:0] acc_size_i,
  input wire logic acc_write_i,
  input wire logic [ebp_pkg::AREA_W-1:0] acc_area_i,
  input wire logic [ebp_pkg::ADDR_W-1:0] acc_addr_i,
  input wire logic [15:0] acc_wdata_i,
  input wire logic [15:0] data_lines_i,
  input wire logic [PORT_W-1:0] port_dir_i,
  input wire logic [PORT_W-1:0] port_out_i,
  output logic [15:0] rdata_o,
  output logic [ebp_pkg::ADDR_W-1:0] address_lines_o,
  output logic read_strobe_n_o,
  output logic upper_write_strobe_n_o,
  output logic lower_write_strobe_n_o,
  output logic [ebp_pkg::NUM_AREAS-1:0] area_select_n_o,
  output logic [ebp_pkg::NUM_AREAS-1:0] area_select_oe_o,
  output logic [15:0] data_lines_o,
  output logic [15:0] data_lines_oe_o,
  output logic [PORT_W-1:0] port_o,
  output logic [PORT_W-1:0] port_oe_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] rdata;
    logic [ebp_pkg::ADDR_W-1:0] addr;
    logic rd_n;
    logic wrh_n;
    logic wrl_n;
    logic [ebp_pkg::NUM_AREAS-1:0] sel_n;
    logic [ebp_pkg::NUM_AREAS-1:0] sel_oe;
    logic [15:0] dout;
    logic [15:0] doe;
    logic [PORT_W-1:0] pout;
    logic [PORT_W-1:0] poe;
  } ebp_state_t;

  ebp_state_t state_reg;
  ebp_state_t state_next;

  logic ext;
  logic upper_lane;
  logic lower_lane;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ext = acc_valid_i && (acc_target_i == ebp_pkg::TGT_EXTERNAL);
    upper_lane = (acc_size_i != ebp_pkg::SZ_LOWER);
    lower_lane = (acc_size_i != ebp_pkg::SZ_UPPER);
    state_next.sync1 = data_lines_i;
    state_next.sync2 = state_reg.sync1;
    // read data captured from the synchronised pins, no logic on sync1
    state_next.rdata = state_reg.sync2;
    // after the first enabled edge every select is driven; area2/3 float until then
    state_next.sel_oe = '1;
    state_next.addr = acc_addr_i;
    state_next.rd_n = !(ext && !acc_write_i);
    state_next.wrh_n = !(ext && acc_write_i && upper_lane);
    state_next.wrl_n = !(ext && acc_write_i && lower_lane);
    state_next.sel_n = '1;
    if (ext) begin
      state_next.sel_n[acc_area_i] = 1'b0;
    end
    // a longword goes out as one 16-bit cycle per access; the caller splits it
    state_next.dout = acc_wdata_i;
    state_next.doe = '0;
    if (ext && acc_write_i) begin
      state_next.doe = {{8{upper_lane}}, {8{lower_lane}}};
    end
    // ports follow their direction setting, in sleep as when awake
    state_next.pout = port_out_i;
    state_next.poe = port_dir_i;
    // sleep stops bus cycles: strobes and selects idle, data floats
    if (sleep_i) begin
      state_next.rd_n = ebp_pkg::STROBE_IDLE;
      state_next.wrh_n = ebp_pkg::STROBE_IDLE;
      state_next.wrl_n = ebp_pkg::STROBE_IDLE;
      state_next.sel_n = '1;
      state_next.doe = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.addr <= ebp_pkg::ADDR_RST;
      state_reg.rd_n <= ebp_pkg::STROBE_IDLE;
      state_reg.wrh_n <= ebp_pkg::STROBE_IDLE;
      state_reg.wrl_n <= ebp_pkg::STROBE_IDLE;
      state_reg.sel_n <= '1;
      state_reg.sel_oe <= 4'h3;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign address_lines_o = state_reg.addr;
  assign read_strobe_n_o = state_reg.rd_n;
  assign upper_write_strobe_n_o = state_reg.wrh_n;
  assign lower_write_strobe_n_o = state_reg.wrl_n;
  assign area_select_n_o = state_reg.sel_n;
  assign area_select_oe_o = state_reg.sel_oe;
  assign data_lines_o = state_reg.dout;
  assign data_lines_oe_o = state_reg.doe;
  assign port_o = state_reg.pout;
  assign port_oe_o = state_reg.poe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ------------------------------------------------------------
  // access kinds
  // ------------------------------------------------------------
  // each kind is named once here; the write, read, sleep, frozen and quiet checks reuse the names,
  // while chk_sel_one_low, chk_sel_internal_high and chk_data_float spell their conditions out inline
  sequence ext_write_s;
    clk_en_i && !sleep_i && acc_valid_i && acc_target_i == ebp_pkg::TGT_EXTERNAL
      && acc_write_i;
  endsequence

  sequence ext_read_s;
    clk_en_i && !sleep_i && acc_valid_i && acc_target_i == ebp_pkg::TGT_EXTERNAL
      && !acc_write_i;
  endsequence

  sequence sleep_s;
    clk_en_i && sleep_i;
  endsequence

  sequence frozen_s;
    !clk_en_i;
  endsequence

  sequence quiet_s;
    clk_en_i && !sleep_i && (!acc_valid_i || acc_target_i != ebp_pkg::TGT_EXTERNAL);
  endsequence

  chk_sel_one_low: assert property (clk_en_i && !sleep_i && acc_valid_i &&
      acc_target_i == ebp_pkg::TGT_EXTERNAL |=> !area_select_n_o[$past(acc_area_i)]
      && $countones(area_select_n_o) == 3)
    else $error("addressed area select not alone low");
  chk_sel_internal_high: assert property (clk_en_i &&
      (!acc_valid_i || acc_target_i != ebp_pkg::TGT_EXTERNAL) |=> &area_select_n_o)
    else $error("select low without external access");
  chk_read_strobes: assert property (ext_read_s |=> !read_strobe_n_o
      && upper_write_strobe_n_o && lower_write_strobe_n_o)
    else $error("read strobe pattern wrong");
  chk_write_lanes: assert property (ext_write_s |=> read_strobe_n_o
      && (upper_write_strobe_n_o == ($past(acc_size_i) == ebp_pkg::SZ_LOWER))
      && (lower_write_strobe_n_o == ($past(acc_size_i) == ebp_pkg::SZ_UPPER)))
    else $error("write strobe pattern wrong");
  chk_data_float: assert property (clk_en_i && !acc_write_i |=> data_lines_oe_o == 16'h0000)
    else $error("data bus driven outside a write");
  chk_data_lanes: assert property (ext_write_s |=>
      data_lines_oe_o[15] == ($past(acc_size_i) != ebp_pkg::SZ_LOWER)
      && data_lines_oe_o[0] == ($past(acc_size_i) != ebp_pkg::SZ_UPPER))
    else $error("data lane enables wrong");
  chk_addr_follow: assert property (clk_en_i |=> address_lines_o == $past(acc_addr_i))
    else $error("address lines do not follow access");
  chk_port_dir: assert property (clk_en_i ##1 clk_en_i |=> port_oe_o == $past(port_dir_i))
    else $error("port direction not kept");
  chk_rst_idle: assert property ($rose(rst_n_i) |-> read_strobe_n_o
      && area_select_oe_o[1:0] == 2'h3)
    else $error("idle pin states wrong after reset");

  // ------------------------------------------------------------
  // sleep, clock enable and data values
  // ------------------------------------------------------------
  // sleep must win over any access presented in the same cycle
  chk_sleep_idle: assert property (sleep_s |=> read_strobe_n_o
      && upper_write_strobe_n_o && lower_write_strobe_n_o && &area_select_n_o
      && data_lines_oe_o == 16'h0000)
    else $error("bus not idle in sleep");
  chk_sleep_ports: assert property (sleep_s |=> port_oe_o == $past(port_dir_i)
      && (port_o & port_oe_o) == ($past(port_out_i) & $past(port_dir_i)))
    else $error("port pins not kept in sleep");
  // a low enable must not let any output move, bus pins included
  chk_enable_hold: assert property (frozen_s |=> $stable(address_lines_o)
      && $stable(read_strobe_n_o) && $stable(area_select_n_o)
      && $stable(data_lines_oe_o) && $stable(port_oe_o))
    else $error("outputs moved while enable low");
  chk_quiet_strobes: assert property (quiet_s |=> read_strobe_n_o
      && upper_write_strobe_n_o && lower_write_strobe_n_o && data_lines_oe_o == 16'h0000)
    else $error("strobe active without external access");
  chk_write_data: assert property (ext_write_s |=> data_lines_o == $past(acc_wdata_i))
    else $error("write data not on lanes");
  // a lane is driven as a whole byte or not at all
  chk_lane_whole: assert property (ext_write_s |=>
      data_lines_oe_o == {{8{data_lines_oe_o[15]}}, {8{data_lines_oe_o[0]}}})
    else $error("lane enable split inside a byte");
  // area2/3 float from reset until the first enabled edge, which drives them
  chk_sel_driven: assert property (clk_en_i |=> area_select_oe_o == 4'hf)
    else $error("area select not driven after reset");

endmodule // ebp_pin_ctrl

/* File: verif/ebp_mem_model.sv */
// far-side memory model answering reads on the data lanes
module ebp_mem_model (
  input wire logic ref_clk_i,
  input wire logic read_strobe_n_i,
  input wire logic [3:0] area_select_n_i,
  input wire logic [20:0] address_lines_i,
  output logic [15:0] mem_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_reg = 16'h0;
  logic drive;
  assign drive = !read_strobe_n_i && area_select_n_i != 4'hf;
  // released lanes show the inverse of the last value so a stale read cannot match
  assign mem_data_o = drive ? address_lines_i[15:0] ^ 16'h5a5a : ~last_reg;
  always @(posedge ref_clk_i) last_reg <= mem_data_o;
endmodule // ebp_mem_model

/* File: verif/ebp_pin_ctrl_tb.sv */
// self-checking bench for the pin-state controller
module ebp_pin_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, rst_n_i = 0, sleep_i = 0, v = 0, wr = 0, rd_n, wh_n, wl_n;
  logic [1:0] tgt = 0, sz = 0, area = 0;
  logic [20:0] addr = 0, ao;
  logic [15:0] wd = 0, pins, md, dout, doe;
  logic [10:0] dir = 0, pout = 0, po, poe;
  logic [3:0] sel, soe;
  logic en = 1;
  logic [15:0] rdata;
  logic [47:0] ph = 48'h0;
  logic [82:0] last = {1'b0, 21'h0, 3'h7, 4'hf, 54'h0};
  logic [82:0] q[$], e;
  int fails = 0, samples_checked = 0, seed = 17832, cyc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  assign pins = (doe & dout) | (~doe & md);
  ebp_mem_model MEM (.ref_clk_i(ref_clk_i), .read_strobe_n_i(rd_n), .area_select_n_i(sel),
    .address_lines_i(ao), .mem_data_o(md));
  ebp_pin_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(en),
    .sleep_i(sleep_i), .acc_valid_i(v), .acc_target_i(tgt), .acc_size_i(sz),
    .acc_write_i(wr), .acc_area_i(area), .acc_addr_i(addr), .acc_wdata_i(wd),
    .data_lines_i(pins), .port_dir_i(dir), .port_out_i(pout), .rdata_o(rdata),
    .address_lines_o(ao), .read_strobe_n_o(rd_n), .upper_write_strobe_n_o(wh_n),
    .lower_write_strobe_n_o(wl_n), .area_select_n_o(sel), .area_select_oe_o(soe),
    .data_lines_o(dout), .data_lines_oe_o(doe), .port_o(po), .port_oe_o(poe));
  task check(input string n, input logic [82:0] x, input logic [82:0] s);
    samples_checked++;
    if (x !== s) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, x, s);
    end
  endtask
  task conclude;
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function logic [82:0] expect_pins();
    logic x;
    logic [15:0] m;
    x = v && !sleep_i && tgt == ebp_pkg::TGT_EXTERNAL;
    m = (x && wr) ? {{8{sz != ebp_pkg::SZ_LOWER}}, {8{sz != ebp_pkg::SZ_UPPER}}} : 16'h0;
    return {v, addr, !(x && !wr), !(x && wr && sz != ebp_pkg::SZ_LOWER),
      !(x && wr && sz != ebp_pkg::SZ_UPPER), x ? ~(4'h1 << area) : 4'hf, m, wd & m,
      dir, pout & dir};
  endfunction
  // ----------------------------------------
  // random traffic, sleep and port setups
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    check("reset", {rd_n, wh_n, wl_n, sel, soe, doe, poe}, {3'h7, 8'hf3, 27'h0});
    rst_n_i <= 1;
    repeat (400) begin
      @(posedge ref_clk_i);
      en <= ($random(seed) & 7) != 0;
      v <= ($random(seed) & 7) != 0;
      sleep_i <= ($random(seed) & 7) == 0;
      tgt <= $random(seed);
      sz <= $random(seed);
      wr <= $random(seed);
      area <= $random(seed);
      addr <= $random(seed);
      wd <= $random(seed);
      dir <= $random(seed);
      pout <= $random(seed);
      #1;
      // a low enable freezes every output, so the previous note stands again
      if (en) last = expect_pins();
      q.push_back(last);
    end
    repeat (2) @(posedge ref_clk_i);
    conclude();
  end
  // outputs at this falling edge belong to the access set one edge earlier
  always @(negedge ref_clk_i) if (q.size() > 1) begin
    e = q.pop_front();
    check("pins", e, {e[82], ao, rd_n, wh_n, wl_n, sel, doe, dout & doe,
      poe, po & poe});
    check("rdata", ph[47:32], rdata);
  end
  // read data trails the pins by two synchroniser stages and one capture stage
  always @(posedge ref_clk_i) if (en && rst_n_i) ph <= {ph[31:0], pins};
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      conclude();
    end
  end
endmodule // ebp_pin_ctrl_tb
